// ===== logic/sctc_clock_trim.sv
// Sample and timing clock configuration registers with clock selection
// Summary of operation
// R01 - Bit 8 selects sample clock source; clear means internal low-rate oscillator.
// R02 - Bypass bit set takes sample clock from external clock on shared sync pin.
// R03 - Bit 7 enables the sample clock; zero disables it; resets to zero.
// R04 - Six-bit sample trim, about 0.6 kHz per step, larger is slower, reset 0x12.
// R05 - Sample trim zero is fastest, 100010 is centre, all ones is slowest.
// R06 - Eight-bit timing trim, about 109 kHz per step, larger codes are faster.
// R07 - Timing trim zero is slowest, 01011110 is reset default, all ones fastest.
// R08 - Converter register 0x0040 selects 1 MHz; 0x0060, the reset value, 500 kHz.
// R09 - Software writes zero to reserved bit 6 of sample control register.
// R10 - Fields read back last write and take effect without a reset.
`include "sctc_params.svh"
module sctc_clock_trim #(
  parameter int SAMPLE_TRIM_W = 6,
  parameter int TIMING_TRIM_W = 8
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst,
  input  wire logic                     i_wr_en,
  input  wire logic [7:0]               i_addr,
  input  wire logic [15:0]              i_wdata,
  output logic      [15:0]              o_rdata,
  input  wire logic                     i_int_osc_clk,
  input  wire logic                     i_shared_sync_pin,
  output logic                          o_sample_clk,
  output logic                          o_sample_src_ext,
  output logic                          o_sample_clock_enable,
  output logic      [SAMPLE_TRIM_W-1:0] o_sample_clock_trim,
  output logic      [TIMING_TRIM_W-1:0] o_timing_clock_trim,
  output sctc_pkg::sctc_conv_speed_e    o_conv_speed
);
  logic [15:0] sample_ctrl_r;
  logic [15:0] timing_trim_r;
  logic [15:0] conv_speed_r;
  logic [15:0] sample_ctrl_nxt;
  logic [15:0] timing_trim_nxt;
  logic [15:0] conv_speed_nxt;
  logic [15:0] rdata_nxt;
  logic        hit_sample_ctrl;
  logic        hit_timing_trim;
  logic        hit_conv_speed;
  logic        hit_mapped;

  // Trim fields must stay below the reserved bits of their registers
  if (SAMPLE_TRIM_W < 1 || SAMPLE_TRIM_W > `SCTC_BIT_SAMPLE_RSVD) begin : g_bad_sample_trim
    $error("sample trim width out of range");
  end
  if (TIMING_TRIM_W < 1 || TIMING_TRIM_W > `SCTC_BIT_TIMING_RSVD) begin : g_bad_timing_trim
    $error("timing trim width out of range");
  end

  // One address decode shared by writes, readback and checks
  assign hit_sample_ctrl = (i_addr == `SCTC_ADDR_SAMPLE_CTRL);
  assign hit_timing_trim = (i_addr == `SCTC_ADDR_TIMING_TRIM);
  assign hit_conv_speed  = (i_addr == `SCTC_ADDR_CONV_SPEED);
  assign hit_mapped      = hit_sample_ctrl | hit_timing_trim | hit_conv_speed;

  // R10 live register writes
  // Reserved bits kept as written, so readback always matches
  always_comb begin
    sample_ctrl_nxt = sample_ctrl_r;
    if (i_wr_en && hit_sample_ctrl) begin
      sample_ctrl_nxt = i_wdata;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sample_ctrl_r <= `SCTC_RST_SAMPLE_CTRL;
    end else begin
      sample_ctrl_r <= sample_ctrl_nxt;
    end
  end

  // R07 timing trim default
  always_comb begin
    timing_trim_nxt = timing_trim_r;
    if (i_wr_en && hit_timing_trim) begin
      timing_trim_nxt = i_wdata;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      timing_trim_r <= `SCTC_RST_TIMING_TRIM;
    end else begin
      timing_trim_r <= timing_trim_nxt;
    end
  end

  // R08 converter speed reset
  always_comb begin
    conv_speed_nxt = conv_speed_r;
    if (i_wr_en && hit_conv_speed) begin
      conv_speed_nxt = i_wdata;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      conv_speed_r <= `SCTC_RST_CONV_SPEED;
    end else begin
      conv_speed_r <= conv_speed_nxt;
    end
  end

  // R10 readback of last write
  // Registered so read data never follows address glitches
  always_comb begin
    rdata_nxt = 16'h0000;
    if (hit_sample_ctrl) begin
      rdata_nxt = sample_ctrl_r;
    end else if (hit_timing_trim) begin
      rdata_nxt = timing_trim_r;
    end else if (hit_conv_speed) begin
      rdata_nxt = conv_speed_r;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  // R01 R02 source select
  assign o_sample_src_ext = sample_ctrl_r[`SCTC_BIT_OSC_BYPASS];
  // R03 enable bit
  assign o_sample_clock_enable = sample_ctrl_r[`SCTC_BIT_SAMPLE_EN];
  // Gated mux; a glitch-free cell replaces this in silicon
  assign o_sample_clk = o_sample_clock_enable &
                        (o_sample_src_ext ? i_shared_sync_pin : i_int_osc_clk);
  // R04 R05 sample trim to oscillator
  assign o_sample_clock_trim = sample_ctrl_r[SAMPLE_TRIM_W-1:0];
  // R06 timing trim to oscillator
  assign o_timing_clock_trim = timing_trim_r[TIMING_TRIM_W-1:0];
  // R08 speed decode; unknown codes fall back to the slow, safe rate
  assign o_conv_speed = (conv_speed_r == `SCTC_CONV_FAST_CODE) ?
                        sctc_pkg::SCTC_CONV_FAST : sctc_pkg::SCTC_CONV_SLOW;

  a_sample_write: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    i_wr_en && i_addr == `SCTC_ADDR_SAMPLE_CTRL |=> sample_ctrl_r == $past(i_wdata))
    else $error("sample control write lost");
  a_timing_write: assert property (@(posedge i_clock) disable iff (i_rst) // R06
    i_wr_en && i_addr == `SCTC_ADDR_TIMING_TRIM |=> o_timing_clock_trim == $past(i_wdata[7:0]))
    else $error("timing trim not applied");
  a_trim_reset: assert property (@(posedge i_clock) // R04
    i_rst |=> o_sample_clock_trim == 6'h12 && !o_sample_clock_enable && !o_sample_src_ext)
    else $error("sample control reset wrong");
  a_timing_reset: assert property (@(posedge i_clock) // R07
    i_rst |=> o_timing_clock_trim == 8'h5e)
    else $error("timing trim reset wrong");
  a_conv_reset: assert property (@(posedge i_clock) // R08
    i_rst |=> o_conv_speed == sctc_pkg::SCTC_CONV_SLOW)
    else $error("converter speed reset wrong");
  a_conv_fast: assert property (@(posedge i_clock) disable iff (i_rst) // R08
    i_wr_en && i_addr == `SCTC_ADDR_CONV_SPEED && i_wdata == 16'h0040
    |=> o_conv_speed == sctc_pkg::SCTC_CONV_FAST)
    else $error("fast converter clock not selected");
  a_clk_gated: assert property (@(posedge i_clock) disable iff (i_rst) // R03
    !o_sample_clock_enable |-> !o_sample_clk)
    else $error("sample clock runs while disabled");
  a_clk_source: assert property (@(posedge i_clock) disable iff (i_rst) // R02
    o_sample_clock_enable && o_sample_src_ext |-> o_sample_clk == i_shared_sync_pin)
    else $error("external clock not selected");
  a_clk_internal: assert property (@(posedge i_clock) disable iff (i_rst) // R01
    o_sample_clock_enable && !o_sample_src_ext |-> o_sample_clk == i_int_osc_clk)
    else $error("internal oscillator not selected");
  a_readback: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    i_addr == `SCTC_ADDR_TIMING_TRIM |=> o_rdata == $past(timing_trim_r))
    else $error("timing trim readback wrong");


  // Field, readback and hold checks
  a_sample_fields: assert property (@(posedge i_clock) disable iff (i_rst) // R03
    i_wr_en && hit_sample_ctrl
    |=> o_sample_clock_enable == $past(i_wdata[`SCTC_BIT_SAMPLE_EN])
        && o_sample_src_ext == $past(i_wdata[`SCTC_BIT_OSC_BYPASS])
        && o_sample_clock_trim == $past(i_wdata[SAMPLE_TRIM_W-1:0]))
    else $error("sample control fields not applied");
  a_conv_slow: assert property (@(posedge i_clock) disable iff (i_rst) // R08
    i_wr_en && hit_conv_speed && i_wdata != `SCTC_CONV_FAST_CODE
    |=> o_conv_speed == sctc_pkg::SCTC_CONV_SLOW)
    else $error("slow converter clock not selected");
  a_sample_rb: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    hit_sample_ctrl
    |=> o_rdata == $past(sample_ctrl_r))
    else $error("sample control readback wrong");
  a_conv_rb: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    hit_conv_speed
    |=> o_rdata == $past(conv_speed_r))
    else $error("converter speed readback wrong");
  a_unmapped_rd: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    !hit_mapped
    |=> o_rdata == 16'h0000)
    else $error("unmapped address did not read zero");
  a_sample_hold: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    !(i_wr_en && hit_sample_ctrl)
    |=> $stable(sample_ctrl_r))
    else $error("sample control changed without a write");
  a_timing_hold: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    !(i_wr_en && hit_timing_trim)
    |=> $stable(timing_trim_r))
    else $error("timing trim changed without a write");
  a_conv_hold: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    !(i_wr_en && hit_conv_speed)
    |=> $stable(conv_speed_r))
    else $error("converter speed changed without a write");
  a_stray_write: assert property (@(posedge i_clock) disable iff (i_rst) // R10
    i_wr_en && !hit_mapped
    |=> $stable(sample_ctrl_r) && $stable(timing_trim_r)
        && $stable(conv_speed_r))
    else $error("unmapped write changed a register");
  a_rdata_reset: assert property (@(posedge i_clock) // R10
    i_rst |=> o_rdata == 16'h0000)
    else $error("read data not cleared by reset");

  // Main scenarios the bench is expected to reach
  c_bypass: cover property (@(posedge i_clock) o_sample_src_ext && o_sample_clock_enable);
  c_fast: cover property (@(posedge i_clock) o_conv_speed == sctc_pkg::SCTC_CONV_FAST);
  c_center: cover property (@(posedge i_clock)
    o_sample_clock_trim == `SCTC_SAMPLE_TRIM_CENTER);
  c_trim_slowest: cover property (@(posedge i_clock)
    o_sample_clock_trim == `SCTC_SAMPLE_TRIM_SLOWEST);
  c_timing_fastest: cover property (@(posedge i_clock)
    o_timing_clock_trim == `SCTC_TIMING_TRIM_FASTEST);
endmodule : sctc_clock_trim

// ===== logic/sctc_params.svh
// Register offsets, field positions and reset values for the clock trim block
`ifndef SCTC_PARAMS_SVH
`define SCTC_PARAMS_SVH
`define SCTC_ADDR_SAMPLE_CTRL   8'h4b
`define SCTC_ADDR_TIMING_TRIM   8'h4d
`define SCTC_ADDR_CONV_SPEED    8'h4e
`define SCTC_BIT_OSC_BYPASS     8
`define SCTC_BIT_SAMPLE_EN      7
`define SCTC_BIT_SAMPLE_RSVD    6
`define SCTC_RST_SAMPLE_CTRL    16'h2612
`define SCTC_RST_TIMING_TRIM    16'h425e
`define SCTC_RST_CONV_SPEED     16'h0060
`define SCTC_CONV_FAST_CODE     16'h0040
`define SCTC_CONV_SLOW_CODE     16'h0060
`define SCTC_SAMPLE_TRIM_CENTER 6'h22
`define SCTC_BIT_TIMING_RSVD    8
`define SCTC_SAMPLE_TRIM_SLOWEST 6'h3f
`define SCTC_TIMING_TRIM_FASTEST 8'hff
`endif

// ===== logic/sctc_pkg.sv
// Types for the clock trim block
package sctc_pkg;
  typedef enum logic [1:0] {
    SCTC_CONV_FAST  = 2'h1,
    SCTC_CONV_SLOW  = 2'h2
  } sctc_conv_speed_e;
endpackage : sctc_pkg

// ===== testbench/sctc_tb.sv
// Self-checking bench for the sample and timing clock trim registers
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       i_clock, i_rst, i_wr_en, i_int_osc_clk, i_shared_sync_pin;
  logic [7:0]                 i_addr, a;
  logic [15:0]                i_wdata, o_rdata, v, s4b, s4d, s4e;
  logic                       o_sample_clk, o_sample_src_ext, o_sample_clock_enable;
  logic [5:0]                 o_sample_clock_trim;
  logic [7:0]                 o_timing_clock_trim;
  sctc_pkg::sctc_conv_speed_e o_conv_speed;
  logic [7:0]                 ad [5] = '{8'h4b, 8'h4d, 8'h4e, 8'h4c, 8'h4f};
  int                         failures, n_checks;
  sctc_clock_trim sctc_clock_trim_i (.i_clock(i_clock), .i_rst(i_rst), .i_wr_en(i_wr_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_int_osc_clk(i_int_osc_clk),
    .i_shared_sync_pin(i_shared_sync_pin), .o_sample_clk(o_sample_clk),
    .o_sample_src_ext(o_sample_src_ext), .o_sample_clock_enable(o_sample_clock_enable),
    .o_sample_clock_trim(o_sample_clock_trim), .o_timing_clock_trim(o_timing_clock_trim),
    .o_conv_speed(o_conv_speed));
  function automatic logic [15:0] exp_conv(input logic [15:0] c);
    return (c === 16'h0040) ? 16'(sctc_pkg::SCTC_CONV_FAST) : 16'(sctc_pkg::SCTC_CONV_SLOW);
  endfunction : exp_conv
  function automatic logic exp_sclk(input logic [15:0] c, input logic pin, input logic osc);
    return c[7] & (c[8] ? pin : osc);
  endfunction : exp_sclk
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Read data lands one edge after the address is taken
  task automatic rd(input logic [7:0] ra, input logic [15:0] exp);
    i_addr = ra;
    @(negedge i_clock);
    check("rdata", o_rdata, exp);
  endtask : rd
  task automatic fields;
    i_int_osc_clk = 1'($urandom);
    i_shared_sync_pin = 1'($urandom);
    #1;
    check("src", o_sample_src_ext, s4b[8]);
    check("en", o_sample_clock_enable, s4b[7]);
    check("strim", o_sample_clock_trim, s4b[5:0]);
    check("ttrim", o_timing_clock_trim, s4d[7:0]);
    check("conv", o_conv_speed, exp_conv(s4e));
    check("sclk", o_sample_clk, exp_sclk(s4b, i_shared_sync_pin, i_int_osc_clk));
    @(negedge i_clock);
  endtask : fields
  // Unmapped writes must leave every shadow untouched
  task automatic wc(input logic [7:0] wa, input logic [15:0] wv);
    i_addr = wa;
    i_wdata = wv;
    i_wr_en = 1'b1;
    @(negedge i_clock);
    i_wr_en = 1'b0;
    if (wa == 8'h4b) s4b = wv;
    if (wa == 8'h4d) s4d = wv;
    if (wa == 8'h4e) s4e = wv;
    rd(wa, (wa inside {8'h4b, 8'h4d, 8'h4e}) ? wv : 16'h0);
    fields();
  endtask : wc
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  initial begin
    #500000;
    failures++;
    tally_and_finish();
  end
  initial begin
    i_rst = 1'b1;
    i_wr_en = 1'b0;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    i_int_osc_clk = 1'b0;
    i_shared_sync_pin = 1'b0;
    {s4b, s4d, s4e} = {16'h2612, 16'h425e, 16'h0060};
    void'($urandom(20));
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    rd(8'h4b, 16'h2612);
    rd(8'h4d, 16'h425e);
    rd(8'h4e, 16'h0060);
    rd(8'h4c, 16'h0000);
    fields();
    wc(8'h4b, 16'h2600);
    wc(8'h4b, 16'h27a2);
    wc(8'h4b, 16'h26bf);
    wc(8'h4d, 16'h4200);
    wc(8'h4d, 16'h42ff);
    wc(8'h4e, 16'h0040);
    wc(8'h4e, 16'h0060);
    wc(8'h4b, 16'h27bf);
    wc(8'h4e, 16'h0040);
    // Mid-run reset must restore every default
    i_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    {s4b, s4d, s4e} = {16'h2612, 16'h425e, 16'h0060};
    rd(8'h4b, 16'h2612);
    rd(8'h4d, 16'h425e);
    rd(8'h4e, 16'h0060);
    fields();
    repeat (60) begin
      a = ad[$urandom_range(4)];
      v = 16'($urandom);
      if (a == 8'h4b) v[6] = 1'b0;
      wc(a, v);
    end
    tally_and_finish();
  end
endmodule : testbench
